// File: shared/ccr_pkg.sv
// constants, types and carriers shared by the cpu control register block
// assumes one 25 MHz system clock and a classic wishbone register master
// What this block does
// - security id control and code addresses move from 0084H/0085H to 1084H/1085H on swap
// - six rom bank areas 0 to 5 chosen by the bank select value
// - 1024-byte high-speed ram decoded at FB00H to FEFFH on every variant
// - FEE0H to FEFFH hold four banks of eight 8-bit general registers
// - high-speed ram is not executable program space
// - expansion ram F000H-F7FFH or E000H-F7FFH, usable for data and code
// - stack lives only in high-speed ram, never expansion ram
// - display memory holds forty 4-bit entries at 00H to 27H
// - peripheral registers sit in FF00H-FFFFH; unassigned ones are not touched
// - program counter steps by instruction length or loads a branch target
// - reset loads the program counter from vector bytes 0000H and 0001H
// - vectors take low byte from even address, high byte from next odd
// - status byte saved on interrupt or push, restored by returns and pop
// - reset sets the status byte to 02H
// - gate flag 0 refuses maskable requests; 1 defers to level, masks, priority
// - gate flag cleared by mask-all and acknowledge, set by unmask-all
// - result-null flag is 1 for a zero result, 0 otherwise
// - two bank select bits record the bank chosen by the switch instruction
// - aux carry set on carry out of or borrow into bit 3
// - service level 0 blocks low priority requests; gate flag still decides
// - carry holds add/sub overflow, rotate shift-out and bit accumulator
// - stack pointer pre-decrements on write, post-increments on read, needs init
package ccr_pkg;
    localparam logic [15:0] VEC_RESET_LO   = 16'h0000;
    localparam logic [15:0] VEC_RESET_HI   = 16'h0001;
    localparam logic [15:0] SEC_CTRL_NORM  = 16'h0084;
    localparam logic [15:0] SEC_CTRL_SWAP  = 16'h1084;
    localparam logic [15:0] SEC_ID_NORM    = 16'h0085;
    localparam logic [15:0] SEC_ID_SWAP    = 16'h1085;
    localparam logic [15:0] SEC_ID_LAST    = 16'h0009;
    localparam logic [2:0]  ROM_BANK_COUNT = 3'h6;
    localparam logic [15:0] FLASH32_TOP    = 16'h7fff;
    localparam logic [15:0] FLASH60_TOP    = 16'hefff;
    localparam logic [15:0] BANK_HI        = 16'hbfff;
    localparam logic [15:0] EXP2K_LO       = 16'hf000;
    localparam logic [15:0] EXP6K_LO       = 16'he000;
    localparam logic [15:0] EXP_HI         = 16'hf7ff;
    localparam logic [15:0] HSRAM_LO       = 16'hfb00;
    localparam logic [15:0] GPR_LO         = 16'hfee0;
    localparam logic [15:0] SFR_LO         = 16'hff00;
    localparam logic [15:0] GPR_TOP_BASE   = 16'hfef8;
    localparam logic [5:0]  DISP_DEPTH     = 6'h28;
    localparam logic [7:0]  PSW_RESET      = 8'h02;
    localparam logic [7:0]  PSW_MASK       = 8'hfb;
    localparam logic [15:0] SP_RESET       = 16'h0000;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [15:0] IRQ_FRAME      = 16'h0003;
    localparam int PSW_IE   = 7;
    localparam int PSW_Z    = 6;
    localparam int PSW_GPR_BANK_SELECT_HIGH = 5;
    localparam int PSW_AC   = 4;
    localparam int PSW_GPR_BANK_SELECT_LOW = 3;
    localparam int PSW_ISP  = 1;
    localparam int PSW_CY   = 0;
    localparam logic [9:0] ADR_PSW   = 10'h000;
    localparam logic [9:0] ADR_SP    = 10'h004;
    localparam logic [9:0] ADR_PC    = 10'h008;
    localparam logic [9:0] ADR_CFG   = 10'h00c;
    localparam logic [9:0] ADR_STAT  = 10'h010;
    localparam logic [1:0] DISP_PAGE = 2'h1;
    typedef enum logic [2:0] {
        RGN_NONE, RGN_FLASH, RGN_BANK, RGN_EXP, RGN_HSRAM, RGN_GPR, RGN_SFR
    } ccr_region_e;
    typedef enum logic [1:0] {
        VAR_32K, VAR_60K, VAR_BANKED, VAR_BANKED_DBG
    } ccr_variant_e;
    typedef struct packed {
        logic       upd_z;
        logic       upd_ac;
        logic       upd_cy;
        logic [7:0] res;
        logic       ac;
        logic       cy;
    } ccr_alu_s;
endpackage : ccr_pkg

// File: hdl/ccr_addr_decode.sv
// address decoder: region of a 16-bit cpu address for the chosen variant
// assumes variant is held stable by the register file
`timescale 1ns/1ps
`default_nettype none
module ccr_addr_decode
    import ccr_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire ccr_variant_e variant,
    output ccr_region_e      region,
    output logic             exec_ok,
    output logic             stack_ok
);
    always_comb begin
        region = RGN_NONE;
        if (addr >= SFR_LO) begin
            region = RGN_SFR;
        end else if (addr >= GPR_LO) begin
            region = RGN_GPR;
        end else if (addr >= HSRAM_LO) begin
            region = RGN_HSRAM;
        end else begin
            case (variant)
                VAR_32K: begin
                    if (addr <= FLASH32_TOP) region = RGN_FLASH;
                end
                VAR_60K: begin
                    if (addr <= FLASH60_TOP) region = RGN_FLASH;
                    else if (addr >= EXP2K_LO && addr <= EXP_HI) region = RGN_EXP;
                end
                default: begin
                    if (addr <= FLASH32_TOP) region = RGN_FLASH;
                    else if (addr <= BANK_HI) region = RGN_BANK;
                    else if (addr >= EXP6K_LO && addr <= EXP_HI) region = RGN_EXP;
                end
            endcase
        end
    end
    // ram above FB00H never runs code; expansion ram does
    assign exec_ok  = (region == RGN_FLASH) || (region == RGN_BANK) || (region == RGN_EXP);
    assign stack_ok = (region == RGN_HSRAM) || (region == RGN_GPR);
endmodule : ccr_addr_decode
`default_nettype wire

// File: hdl/ccr_disp_ram.sv
// display memory: forty 4-bit entries in flip-flops, bus port and scan port
// assumes indices at or above forty are ignored on write and read as zero
`timescale 1ns/1ps
`default_nettype none
module ccr_disp_ram
    import ccr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       we,
    input  wire logic [5:0] idx,
    input  wire logic [3:0] wdata,
    output logic      [3:0] rdata,
    input  wire logic [5:0] scan_idx,
    output logic      [3:0] scan_data
);
    logic [3:0] cell_reg [0:39];
    genvar i;
    generate
        for (i = 0; i < 40; i++) begin : g_cell
            always_ff @(posedge clk_sys) begin
                if (reset) cell_reg[i] <= 4'h0;
                else if (we && idx == 6'(i)) cell_reg[i] <= wdata;
            end
        end
    endgenerate
    assign rdata     = (idx < DISP_DEPTH) ? cell_reg[idx] : 4'h0;
    assign scan_data = (scan_idx < DISP_DEPTH) ? cell_reg[scan_idx] : 4'h0;
endmodule : ccr_disp_ram
`default_nettype wire

// File: hdl/ccr_cpu_ctrl.sv
// cpu control registers: program counter, status byte, stack pointer,
// memory decode and display memory behind a classic wishbone slave
// assumes the core issues at most one stack operation per cycle
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccr_cpu_ctrl
    import ccr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [15:0] mem_addr_o,
    output logic             mem_rd_o,
    input  wire logic [7:0]  mem_rdata_i,
    output logic      [15:0] next_fetch_address_o,
    output logic             fetch_valid_o,
    input  wire logic        instr_step_i,
    input  wire logic [2:0]  instr_len_i,
    input  wire logic        branch_i,
    input  wire logic [15:0] branch_target_i,
    input  wire ccr_alu_s    alu_i,
    input  wire logic        mask_all_instr_i,
    input  wire logic        unmask_all_instr_i,
    input  wire logic        gpr_bank_switch_instr_i,
    input  wire logic [1:0]  gpr_bank_value_i,
    input  wire logic        psw_push_i,
    input  wire logic        psw_pop_i,
    input  wire logic        interrupt_return_instr_i,
    input  wire logic [7:0]  psw_pop_data_i,
    input  wire logic        stack_push_i,
    input  wire logic        stack_pop_i,
    input  wire logic        irq_req_i,
    input  wire logic        irq_masked_i,
    input  wire logic        irq_low_i,
    output logic             irq_take_o,
    output logic      [7:0]  processor_status_byte_o,
    output logic      [15:0] stack_top_pointer_o,
    output logic      [15:0] gpr_base_o,
    output logic      [2:0]  rom_bank_o,
    output logic      [15:0] sec_ctrl_addr_o,
    output logic      [15:0] sec_id_first_o,
    output logic      [15:0] sec_id_last_o,
    output logic             sec_id_valid_o,
    output logic             exec_fault_o,
    output logic             stack_fault_o,
    input  wire logic [5:0]  disp_scan_idx_i,
    output logic      [3:0]  disp_scan_data_o
);
    typedef enum {ST_VLO, ST_VHI, ST_VEND, ST_RUN} ccr_boot_e;

    ccr_boot_e    state_reg;
    logic [15:0]  pc_reg;
    logic [15:0]  mem_addr_reg;
    logic         mem_rd_reg;
    logic [7:0]   psw_reg;
    logic [7:0]   psw_next;
    logic [15:0]  sp_reg;
    logic [15:0]  sp_next;
    logic [15:0]  sp_chk;
    ccr_variant_e variant_reg;
    logic         swap_reg;
    logic [2:0]   bank_reg;
    logic         ack_reg;
    logic [31:0]  dat_reg;
    logic [31:0]  rd_mux;
    logic         exec_fault_reg;
    logic         stack_fault_reg;
    logic [15:0]  gpr_base_reg;
    logic [15:0]  sec_ctrl_reg;
    logic [15:0]  sec_first_reg;
    logic [15:0]  sec_last_reg;
    logic         sec_valid_reg;
    ccr_region_e  pc_rgn;
    ccr_region_e  sp_rgn;
    logic         pc_exec_ok;
    logic         sp_stack_ok;
    logic [3:0]   disp_rdata;
    logic         wb_req;
    logic         wr_fire;
    logic         disp_hit;
    logic         psw_bus_wr;
    logic         sp_bus_wr;
    logic         psw_load;
    logic         push_op;
    logic         pop_op;
    logic         run;

    assign run    = (state_reg == ST_RUN);
    assign wb_req = wb_cyc_i & wb_stb_i;
    // writes land on the edge where ack is seen, so a held request acts again every second cycle
    assign wr_fire    = wb_req & wb_we_i & ack_reg;
    assign disp_hit   = (wb_adr_i[9:8] == DISP_PAGE);
    assign psw_bus_wr = wr_fire & (wb_adr_i == ADR_PSW) & wb_sel_i[0];
    assign sp_bus_wr  = wr_fire & (wb_adr_i == ADR_SP) & (wb_sel_i[1] | wb_sel_i[0]);
    assign psw_load   = psw_pop_i | interrupt_return_instr_i;
    assign push_op    = stack_push_i | psw_push_i;
    assign pop_op     = stack_pop_i | psw_pop_i;

    // boot sequence: vector low byte, then high byte, then run
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_VLO;
        end else begin
            case (state_reg)
                ST_VLO:  state_reg <= ST_VHI;
                ST_VHI:  state_reg <= ST_VEND;
                ST_VEND: state_reg <= ST_RUN;
                ST_RUN:  state_reg <= ST_RUN;
                default: state_reg <= ST_VLO;
            endcase
        end
    end

    // read data is valid the cycle after the address is presented
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_addr_reg <= VEC_RESET_LO;
            mem_rd_reg   <= 1'b1;
        end else if (state_reg == ST_VLO) begin
            mem_addr_reg <= VEC_RESET_HI;
        end else if (state_reg == ST_VHI) begin
            mem_rd_reg   <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pc_reg <= PC_RESET;
        end else begin
            case (state_reg)
                ST_VHI:  pc_reg[7:0]  <= mem_rdata_i;
                ST_VEND: pc_reg[15:8] <= mem_rdata_i;
                ST_RUN: begin
                    if (branch_i) pc_reg <= branch_target_i;
                    else if (instr_step_i) pc_reg <= pc_reg + {13'h0, instr_len_i};
                end
                default: pc_reg <= pc_reg;
            endcase
        end
    end

    // acceptance: gate flag first, then masks and service level
    assign irq_take_o = run & psw_reg[PSW_IE] & irq_req_i & ~irq_masked_i
                        & (~irq_low_i | psw_reg[PSW_ISP]);

    always_comb begin
        psw_next = psw_reg;
        if (psw_bus_wr) psw_next = wb_dat_i[7:0] & PSW_MASK;
        // core updates override a bus write landing in the same cycle
        if (alu_i.upd_z) psw_next[PSW_Z] = (alu_i.res == 8'h00);
        if (alu_i.upd_ac) psw_next[PSW_AC] = alu_i.ac;
        if (alu_i.upd_cy) psw_next[PSW_CY] = alu_i.cy;
        if (gpr_bank_switch_instr_i) begin
            psw_next[PSW_GPR_BANK_SELECT_HIGH] = gpr_bank_value_i[1];
            psw_next[PSW_GPR_BANK_SELECT_LOW] = gpr_bank_value_i[0];
        end
        if (unmask_all_instr_i) psw_next[PSW_IE] = 1'b1;
        if (mask_all_instr_i) psw_next[PSW_IE] = 1'b0;
        if (psw_load) psw_next = psw_pop_data_i & PSW_MASK;
        if (irq_take_o) psw_next[PSW_IE] = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            psw_reg      <= PSW_RESET;
            gpr_base_reg <= GPR_TOP_BASE;
        end else begin
            psw_reg      <= psw_next;
            gpr_base_reg <= GPR_TOP_BASE
                            - {11'h0, psw_next[PSW_GPR_BANK_SELECT_HIGH], psw_next[PSW_GPR_BANK_SELECT_LOW], 3'h0};
        end
    end

    // interrupt entry saves status plus return address: three bytes
    always_comb begin
        sp_next = sp_reg;
        if (sp_bus_wr) begin
            if (wb_sel_i[1]) sp_next[15:8] = wb_dat_i[15:8];
            if (wb_sel_i[0]) sp_next[7:0] = wb_dat_i[7:0];
        end
        if (irq_take_o) sp_next = sp_reg - IRQ_FRAME;
        else if (interrupt_return_instr_i) sp_next = sp_reg + IRQ_FRAME;
        else if (push_op) sp_next = sp_reg - 16'h0001;
        else if (pop_op) sp_next = sp_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) sp_reg <= SP_RESET;
        else sp_reg <= sp_next;
    end

    // pushes write below the old pointer, pops read at it
    assign sp_chk = (push_op | irq_take_o) ? sp_next : sp_reg;

    ccr_addr_decode u_pc_dec (
        .addr     (pc_reg),
        .variant  (variant_reg),
        .region   (pc_rgn),
        .exec_ok  (pc_exec_ok),
        .stack_ok ()
    );

    ccr_addr_decode u_sp_dec (
        .addr     (sp_chk),
        .variant  (variant_reg),
        .region   (sp_rgn),
        .exec_ok  (),
        .stack_ok (sp_stack_ok)
    );

    // sticky; a new fault beats a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stack_fault_reg <= 1'b0;
        end else if ((push_op | pop_op | irq_take_o | interrupt_return_instr_i)
                     & ~sp_stack_ok) begin
            stack_fault_reg <= 1'b1;
        end else if (wr_fire & (wb_adr_i == ADR_STAT) & wb_sel_i[1] & wb_dat_i[9]) begin
            stack_fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) exec_fault_reg <= 1'b0;
        else exec_fault_reg <= run & ~pc_exec_ok;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            variant_reg <= VAR_32K;
            swap_reg    <= 1'b0;
            bank_reg    <= 3'h0;
        end else if (wr_fire & (wb_adr_i == ADR_CFG) & wb_sel_i[0]) begin
            variant_reg <= ccr_variant_e'(wb_dat_i[1:0]);
            swap_reg    <= wb_dat_i[2];
            // out-of-range bank numbers are dropped, the old bank stays
            if (wb_dat_i[6:4] < ROM_BANK_COUNT) bank_reg <= wb_dat_i[6:4];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sec_ctrl_reg  <= SEC_CTRL_NORM;
            sec_first_reg <= SEC_ID_NORM;
            sec_last_reg  <= SEC_ID_NORM + SEC_ID_LAST;
            sec_valid_reg <= 1'b0;
        end else begin
            sec_ctrl_reg  <= swap_reg ? SEC_CTRL_SWAP : SEC_CTRL_NORM;
            sec_first_reg <= swap_reg ? SEC_ID_SWAP : SEC_ID_NORM;
            sec_last_reg  <= (swap_reg ? SEC_ID_SWAP : SEC_ID_NORM) + SEC_ID_LAST;
            sec_valid_reg <= (variant_reg == VAR_BANKED_DBG);
        end
    end

    ccr_disp_ram u_disp (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .we        (wr_fire & disp_hit & wb_sel_i[0]),
        .idx       (wb_adr_i[7:2]),
        .wdata     (wb_dat_i[3:0]),
        .rdata     (disp_rdata),
        .scan_idx  (disp_scan_idx_i),
        .scan_data (disp_scan_data_o)
    );

    always_comb begin
        rd_mux = 32'h0;
        if (disp_hit) begin
            rd_mux = {28'h0, disp_rdata};
        end else begin
            case (wb_adr_i)
                ADR_PSW:  rd_mux = {24'h0, psw_reg};
                ADR_SP:   rd_mux = {16'h0, sp_reg};
                ADR_PC:   rd_mux = {15'h0, run, pc_reg};
                ADR_CFG:  rd_mux = {25'h0, bank_reg, 1'b0, swap_reg, variant_reg};
                ADR_STAT: rd_mux = {22'h0, stack_fault_reg, exec_fault_reg, 2'h0,
                                    sp_rgn, pc_rgn};
                default:  rd_mux = 32'h0;
            endcase
        end
    end

    // one-cycle answer; ack drops after one cycle even if stb stays high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
            if (wb_req & ~ack_reg) dat_reg <= rd_mux;
        end
    end

    assign wb_ack_o                = ack_reg;
    assign wb_dat_o                = dat_reg;
    assign mem_addr_o              = mem_addr_reg;
    assign mem_rd_o                = mem_rd_reg;
    assign next_fetch_address_o    = pc_reg;
    assign fetch_valid_o           = run;
    assign processor_status_byte_o = psw_reg;
    assign stack_top_pointer_o     = sp_reg;
    assign gpr_base_o              = gpr_base_reg;
    assign rom_bank_o              = bank_reg;
    assign sec_ctrl_addr_o         = sec_ctrl_reg;
    assign sec_id_first_o          = sec_first_reg;
    assign sec_id_last_o           = sec_last_reg;
    assign sec_id_valid_o          = sec_valid_reg;
    assign exec_fault_o            = exec_fault_reg;
    assign stack_fault_o           = stack_fault_reg;

    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_vec_lo;
        mem_rd_o && mem_addr_o == VEC_RESET_LO;
    endsequence
    sequence s_vec_hi;
        mem_rd_o && mem_addr_o == VEC_RESET_HI;
    endsequence

    a_vec_order: assert property ($fell(reset) |-> s_vec_lo ##1 s_vec_hi ##1 !mem_rd_o)
        else $error("vector bytes not read in order");
    a_vec_load: assert property ((state_reg == ST_VEND) |=>
        pc_reg == {$past(mem_rdata_i), $past(mem_rdata_i, 2)} && fetch_valid_o)
        else $error("pc not loaded from vector");
    a_psw_init: assert property ($fell(reset) |-> psw_reg == PSW_RESET)
        else $error("status byte reset value wrong");
    a_pc_step: assert property (run && instr_step_i && !branch_i |=>
        pc_reg == $past(pc_reg) + {13'h0, $past(instr_len_i)})
        else $error("pc did not advance by length");
    a_irq_gate: assert property (!psw_reg[PSW_IE] |-> !irq_take_o)
        else $error("request taken with gate flag clear");
    a_low_prio: assert property (irq_take_o && irq_low_i |-> psw_reg[PSW_ISP])
        else $error("low priority taken at service level 0");
    a_ie_clear: assert property (irq_take_o |=> !psw_reg[PSW_IE]
        && sp_reg == $past(sp_reg) - IRQ_FRAME)
        else $error("acknowledge did not clear gate or save frame");
    a_zero_flag: assert property (alu_i.upd_z && !psw_load |=>
        psw_reg[PSW_Z] == ($past(alu_i.res) == 8'h00))
        else $error("result-null flag wrong");
    a_sp_push: assert property (push_op && !irq_take_o && !interrupt_return_instr_i |=>
        sp_reg == $past(sp_reg) - 16'h0001)
        else $error("stack pointer not decremented");
    a_stack_fault: assert property (push_op && !sp_stack_ok |=> stack_fault_o[*2])
        else $error("stack outside high-speed ram not flagged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule : ccr_cpu_ctrl
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the cpu control register block
// drives wishbone and core strobes itself; vector bytes answered per address
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ccr_pkg::*;
    logic        clk_sys, reset, cyc, stb, we, mem_rd, fv, step, br, msk, umsk, bsw;
    logic        ppush, ppop, iret, spush, spop, irq, irq_msk, irq_low, take, sec_ok;
    logic        exec_f, stk_f, ack;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [15:0] maddr, pc, target, sp, gbase, sec_c, sec_f, sec_l;
    logic [7:0]  mdat, pop_d, processor_status_byte;
    logic [2:0]  len, rbank;
    logic [1:0]  bval;
    logic [5:0]  scan;
    logic [3:0]  scan_d;
    ccr_alu_s    alu;
    int          n_mismatch, num_checks, i;

    ccr_cpu_ctrl u_ccr_cpu_ctrl (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .mem_addr_o(maddr), .mem_rd_o(mem_rd),
        .mem_rdata_i(mdat), .next_fetch_address_o(pc), .fetch_valid_o(fv),
        .instr_step_i(step), .instr_len_i(len), .branch_i(br), .branch_target_i(target),
        .alu_i(alu), .mask_all_instr_i(msk), .unmask_all_instr_i(umsk),
        .gpr_bank_switch_instr_i(bsw), .gpr_bank_value_i(bval), .psw_push_i(ppush),
        .psw_pop_i(ppop), .interrupt_return_instr_i(iret), .psw_pop_data_i(pop_d),
        .stack_push_i(spush), .stack_pop_i(spop), .irq_req_i(irq), .irq_masked_i(irq_msk),
        .irq_low_i(irq_low), .irq_take_o(take), .processor_status_byte_o(processor_status_byte),
        .stack_top_pointer_o(sp), .gpr_base_o(gbase), .rom_bank_o(rbank),
        .sec_ctrl_addr_o(sec_c), .sec_id_first_o(sec_f), .sec_id_last_o(sec_l),
        .sec_id_valid_o(sec_ok), .exec_fault_o(exec_f), .stack_fault_o(stk_f),
        .disp_scan_idx_i(scan), .disp_scan_data_o(scan_d));

    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    // vector bytes follow the address shown one cycle earlier
    always @(posedge clk_sys) mdat <= maddr[0] ? 8'h12 : 8'h34;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        k = 0;
        // ack and read data taken at the rising edge, request dropped right after it
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 0; stb <= 0; we <= 0;
        if (ack !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
    endtask : wb

    // drops every core strobe, then waits for the result to settle
    task automatic settle;
        @(posedge clk_sys);
        {step, br, msk, umsk, bsw, ppush, ppop, iret, spush, spop} <= '0;
        alu <= '0;
        @(negedge clk_sys);
    endtask : settle

    initial begin
        reset = 1; {cyc, stb, we, step, br, msk, umsk, bsw, ppush, ppop, iret} = '0;
        {spush, spop, irq, irq_msk, irq_low} = '0; adr = '0; wdat = '0; len = '0;
        target = '0; alu = '0; bval = '0; pop_d = '0; scan = '0; mdat = '0;
        repeat (5) @(posedge clk_sys);
        reset <= 0;
        for (i = 0; i < 20 && fv !== 1'b1; i++) @(negedge clk_sys);
        if (fv !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        check("boot pc", pc, 16'h1234);
        check("reset status", processor_status_byte, 8'h02);
        check("bank0 base", gbase, 16'hfef8);
        wb(0, ADR_PSW, 0); check("status read", q, 32'h02);
        @(posedge clk_sys); step <= 1; len <= 3'h3; settle();
        check("pc step", pc, 16'h1237);
        @(posedge clk_sys); step <= 1; br <= 1; target <= 16'h0100; settle();
        check("pc branch", pc, 16'h0100);
        wb(1, ADR_SP, 32'hfef0); wb(0, ADR_SP, 0); check("sp rw", q, 32'hfef0);
        @(posedge clk_sys); spush <= 1; settle(); check("sp push", sp, 16'hfeef);
        @(posedge clk_sys); spop <= 1; settle(); check("sp pop", sp, 16'hfef0);
        @(posedge clk_sys); irq <= 1; @(negedge clk_sys);
        check("take gated", take, 1'b0);
        @(posedge clk_sys); umsk <= 1; settle(); check("take open", take, 1'b1);
        // an open request is acknowledged at the very next edge
        settle(); check("ack gate", processor_status_byte[7], 1'b0);
        check("irq frame", sp, 16'hfeed);
        wb(1, ADR_PSW, 32'h80); irq_low <= 1; @(negedge clk_sys);
        check("low blocked", take, 1'b0);
        wb(1, ADR_PSW, 32'h82); @(negedge clk_sys); check("low taken", take, 1'b1);
        @(posedge clk_sys); irq <= 0; @(negedge clk_sys);
        check("low ack gate", processor_status_byte[7], 1'b0);
        check("low irq frame", sp, 16'hfeea);
        @(posedge clk_sys); iret <= 1; pop_d <= 8'h86; settle();
        check("return psw", processor_status_byte, 8'h82);
        check("return sp", sp, 16'hfeed);
        @(posedge clk_sys); umsk <= 1; settle(); @(posedge clk_sys); msk <= 1; settle();
        check("mask all", processor_status_byte[7], 1'b0);
        @(posedge clk_sys); alu <= {3'b111, 8'h00, 2'b11}; settle();
        check("flags set", processor_status_byte & 8'h51, 8'h51);
        @(posedge clk_sys); alu <= {3'b111, 8'h05, 2'b00}; settle();
        check("flags clear", processor_status_byte & 8'h51, 8'h00);
        @(posedge clk_sys); bsw <= 1; bval <= 2'h3; settle();
        check("bank bits", processor_status_byte & 8'h28, 8'h28);
        check("bank3 base", gbase, 16'hfee0);
        @(posedge clk_sys); ppop <= 1; pop_d <= 8'hff; settle();
        check("pop psw", processor_status_byte, 8'hfb);
        check("pop sp", sp, 16'hfeee);
        wb(1, ADR_CFG, 32'h57); @(negedge clk_sys); @(negedge clk_sys);
        check("rom bank", rbank, 3'h5);
        check("sec ctrl", sec_c, 16'h1084);
        check("sec id", {sec_f, sec_l}, 32'h1085108e);
        check("sec valid", sec_ok, 1'b1);
        wb(1, ADR_CFG, 32'h63); @(negedge clk_sys); @(negedge clk_sys);
        check("bank refused", rbank, 3'h5);
        check("sec normal", sec_c, 16'h0084);
        wb(1, 10'h19c, 32'h9); wb(0, 10'h19c, 0); check("disp rw", q, 32'h9);
        scan <= 6'h27; @(negedge clk_sys); check("disp scan", scan_d, 4'h9);
        @(posedge clk_sys); scan <= 6'h28; @(negedge clk_sys);
        check("disp past end", scan_d, 4'h0);
        wb(0, 10'h3fc, 0); check("unmapped", q, 32'h0);
        wb(1, ADR_SP, 32'hf100); @(posedge clk_sys); spush <= 1; settle();
        check("exp stack", stk_f, 1'b1);
        // code fetched from high-speed ram must raise the fault a cycle later
        @(posedge clk_sys); br <= 1; target <= 16'hfb00; settle(); @(negedge clk_sys);
        check("exec fault", exec_f, 1'b1);
        wb(0, ADR_STAT, 0); check("stat faults", q[9:8], 2'h3);
        wb(1, ADR_STAT, 32'h200); @(negedge clk_sys);
        check("fault clear", stk_f, 1'b0);
        stop_test();
    end
endmodule : tb
`default_nettype wire
